// ### logic/sltx_core.sv
// transmit path and control register two of the serial interface, wishbone slave
//
// Design decisions made here: register access over Wishbone and the address map.
`timescale 1ns/1ps
`include "sltx_regs.svh"
module sltx_core (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    input wire logic baud_tick_i,
    input wire logic irq_mask_i,
    input wire sltx_pkg::sltx_rx_s rx_i,
    output logic tx_o,
    output logic sclk_o,
    output logic tx_active_o,
    output logic rx_enable_o,
    output logic mute_o,
    output logic irq_o
);
    import sltx_pkg::*;

    // ----------------------------------------
    // bus slave
    // ----------------------------------------
    logic ack_r;
    logic [31:0] dat_r;
    logic [7:0] ctrl2_r;
    logic [7:0] ctrl1_r;
    logic hold_empty_r;
    logic done_r;
    logic status_seen_r;
    sltx_req_s req;
    logic acc;
    logic wr_data;
    logic rd_status;
    logic wr_ctrl2;
    logic wr_ctrl1;
    logic [7:0] status_v;

    assign req = '{adr: adr_i, dat: dat_i[7:0], we: we_i, stb: cyc_i & stb_i};
    assign acc = req.stb & ~ack_r;
    assign ack_o = ack_r;
    assign dat_o = dat_r;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
        hit = (a == b);
    endfunction

    assign wr_data = acc & req.we & sel_i[0] & hit(req.adr, `SLTX_DATA_ADDR);
    assign wr_ctrl2 = acc & req.we & sel_i[0] & hit(req.adr, `SLTX_CTRL2_ADDR);
    assign wr_ctrl1 = acc & req.we & sel_i[0] & hit(req.adr, `SLTX_CTRL1_ADDR);
    assign rd_status = acc & ~req.we & hit(req.adr, `SLTX_STATUS_ADDR);

    always_comb begin
        status_v = 8'h00;
        status_v[`SLTX_SR_HOLD] = hold_empty_r;
        status_v[`SLTX_SR_DONE] = done_r;
        status_v[`SLTX_SR_FULL] = rx_i.rx_full;
        status_v[`SLTX_SR_IDLE] = rx_i.idle_line;
        status_v[`SLTX_SR_OVR] = rx_i.overrun;
    end

    // one wait state; unmapped reads return zero, writes ignored
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_r <= 1'b0;
            dat_r <= 32'h0000_0000;
        end else begin
            ack_r <= acc;
            if (acc && !req.we) begin
                if (hit(req.adr, `SLTX_STATUS_ADDR)) begin
                    dat_r <= {24'h00_0000, status_v};
                end else if (hit(req.adr, `SLTX_CTRL2_ADDR)) begin
                    dat_r <= {24'h00_0000, ctrl2_r};
                end else if (hit(req.adr, `SLTX_CTRL1_ADDR)) begin
                    dat_r <= {24'h00_0000, ctrl1_r};
                end else begin
                    dat_r <= 32'h0000_0000;
                end
            end
        end
    end

    // ----------------------------------------
    // control registers
    // ----------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl1_r <= `SLTX_CTRL1_RST;
        end else if (wr_ctrl1) begin
            ctrl1_r <= req.dat;
        end
    end

    logic mute_lock;
    assign mute_lock = ctrl1_r[`SLTX_C1_WAKE] & rx_i.rx_full;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl2_r <= `SLTX_CTRL2_RST;
        end else begin
            if (wr_ctrl2) begin
                ctrl2_r[7:2] <= req.dat[7:2];
                ctrl2_r[`SLTX_C2_BREAK] <= req.dat[`SLTX_C2_BREAK];
                if (!mute_lock) begin
                    ctrl2_r[`SLTX_C2_MUTE] <= req.dat[`SLTX_C2_MUTE];
                end
            end
            // hardware wake wins over a software write in the same cycle
            if (rx_i.wake_seen) begin
                ctrl2_r[`SLTX_C2_MUTE] <= 1'b0;
            end
        end
    end

    assign rx_enable_o = ctrl2_r[`SLTX_C2_RX_EN];
    assign mute_o = ctrl2_r[`SLTX_C2_MUTE];

    // ----------------------------------------
    // transmitter
    // ----------------------------------------
    sltx_state_e state_r;
    logic [8:0] shift_r;
    logic [3:0] cnt_r;
    logic [7:0] hold_r;
    logic hold_full_r;
    logic hold_ninth_r;
    logic tx_r;
    logic sclk_r;
    logic te_d_r;
    logic te_off_seen_r;
    logic brk_d_r;
    logic brk_pulse_r;
    logic word9;
    logic te;
    logic brk;
    logic [3:0] frame_len;
    logic [3:0] break_len;
    logic frame_end;
    logic load_direct;
    logic load_hold;
    logic start_break;

    assign word9 = ctrl1_r[`SLTX_C1_WORD9];
    assign te = ctrl2_r[`SLTX_C2_TX_EN];
    assign brk = ctrl2_r[`SLTX_C2_BREAK];
    assign frame_len = word9 ? `SLTX_LEN9 : `SLTX_LEN8;
    assign break_len = ctrl1_r[`SLTX_C1_LIN] ? `SLTX_LIN_BREAK : frame_len;
    assign frame_end = baud_tick_i && cnt_r == 4'h1;
    assign start_break = brk | brk_pulse_r;
    assign load_direct = wr_data && state_r == SLTX_READY && !hold_full_r && !start_break;
    assign load_hold = state_r == SLTX_READY && hold_full_r && !start_break;

    // catch a break bit that was set and cleared while a word was busy
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            brk_d_r <= 1'b0;
            brk_pulse_r <= 1'b0;
        end else begin
            brk_d_r <= brk;
            if (brk_d_r && !brk && state_r != SLTX_READY) begin
                brk_pulse_r <= 1'b1;
            end else if (state_r == SLTX_BREAK_FR) begin
                brk_pulse_r <= 1'b0;
            end
        end
    end

    // an off-on pulse on the enable during a word requests an idle preamble
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            te_d_r <= 1'b0;
            te_off_seen_r <= 1'b0;
        end else begin
            te_d_r <= te;
            if (!te && state_r != SLTX_OFF && state_r != SLTX_READY) begin
                te_off_seen_r <= 1'b1;
            end else if (state_r == SLTX_IDLE_FR || state_r == SLTX_OFF) begin
                te_off_seen_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_r <= SLTX_OFF;
            cnt_r <= 4'h0;
            shift_r <= 9'h1FF;
        end else begin
            case (state_r)
                SLTX_OFF: begin
                    if (te) begin
                        state_r <= SLTX_WAIT;
                        cnt_r <= 4'h1;
                    end
                end
                SLTX_WAIT: begin
                    if (frame_end) begin
                        state_r <= SLTX_IDLE_FR;
                        cnt_r <= frame_len;
                    end
                end
                SLTX_IDLE_FR: begin
                    if (frame_end) begin
                        state_r <= SLTX_READY;
                    end else if (baud_tick_i) begin
                        cnt_r <= cnt_r - 4'h1;
                    end
                end
                SLTX_READY: begin
                    if (!te) begin
                        state_r <= SLTX_OFF;
                    end else if (start_break) begin
                        state_r <= SLTX_BREAK_FR;
                        cnt_r <= break_len + 4'h1;
                    end else if (load_direct || load_hold) begin
                        state_r <= SLTX_DATA_FR;
                        cnt_r <= frame_len + 4'h1;
                        if (load_direct) begin
                            shift_r <= {ctrl1_r[`SLTX_C1_NINTH], req.dat};
                        end else begin
                            shift_r <= {hold_ninth_r, hold_r};
                        end
                    end
                end
                SLTX_DATA_FR: begin
                    if (frame_end) begin
                        // a re-enable mid word goes to the idle preamble
                        state_r <= te_off_seen_r ? SLTX_WAIT : SLTX_READY;
                        cnt_r <= 4'h1;
                    end else if (baud_tick_i) begin
                        cnt_r <= cnt_r - 4'h1;
                        if (cnt_r < frame_len) begin
                            shift_r <= {1'b1, shift_r[8:1]};
                        end
                    end
                end
                SLTX_BREAK_FR: begin
                    if (frame_end) begin
                        if (brk) begin
                            cnt_r <= break_len;
                        end else begin
                            state_r <= SLTX_MARK;
                            cnt_r <= 4'h1;
                        end
                    end else if (baud_tick_i) begin
                        cnt_r <= cnt_r - 4'h1;
                    end
                end
                SLTX_MARK: begin
                    if (frame_end) begin
                        state_r <= SLTX_READY;
                    end
                end
                default: begin
                    state_r <= SLTX_OFF;
                end
            endcase
        end
    end

    // slot above frame_len waits for a tick, so the start bit is a full bit
    logic [3:0] pos;
    assign pos = frame_len - cnt_r;

    always_comb begin
        tx_r = 1'b1;
        if (state_r == SLTX_DATA_FR && cnt_r <= frame_len) begin
            if (pos == 4'h0) begin
                tx_r = 1'b0;
            end else if (cnt_r == 4'h1) begin
                tx_r = 1'b1;
            end else begin
                tx_r = shift_r[0];
            end
        end else if (state_r == SLTX_BREAK_FR && cnt_r <= break_len) begin
            tx_r = 1'b0;
        end
    end

    logic tx_q_r;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tx_q_r <= 1'b1;
            sclk_r <= 1'b0;
        end else begin
            tx_q_r <= tx_r;
            // clock pulse marks each data bit
            sclk_r <= baud_tick_i && state_r == SLTX_DATA_FR && cnt_r < frame_len && cnt_r != 4'h1;
        end
    end
    assign tx_o = tx_q_r;
    assign sclk_o = sclk_r;
    assign tx_active_o = state_r == SLTX_DATA_FR || state_r == SLTX_BREAK_FR;

    // ----------------------------------------
    // holding buffer and flags
    // ----------------------------------------
    logic clr_seq;
    assign clr_seq = wr_data & status_seen_r;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            status_seen_r <= 1'b0;
        end else if (rd_status) begin
            status_seen_r <= 1'b1;
        end else if (wr_data) begin
            status_seen_r <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            hold_full_r <= 1'b0;
            hold_r <= 8'h00;
            hold_ninth_r <= 1'b0;
        end else begin
            if (state_r == SLTX_OFF || (te_off_seen_r && te && !te_d_r)) begin
                hold_full_r <= 1'b0;
            end else if (wr_data && !load_direct) begin
                hold_full_r <= 1'b1;
                hold_r <= req.dat;
                hold_ninth_r <= ctrl1_r[`SLTX_C1_NINTH];
            end else if (load_hold) begin
                hold_full_r <= 1'b0;
            end
        end
    end

    // set wins over a same-cycle clear for frame-done and for a direct load; a clearing data write beats the other holding-empty sets
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            hold_empty_r <= 1'b1;
            done_r <= 1'b0;
        end else begin
            if (load_direct || (load_hold && !wr_data) || (!hold_full_r && !wr_data)) begin
                hold_empty_r <= 1'b1;
            end else if (clr_seq) begin
                hold_empty_r <= 1'b0;
            end
            if (frame_end && (state_r == SLTX_DATA_FR || state_r == SLTX_BREAK_FR)) begin
                done_r <= 1'b1;
            end else if (clr_seq) begin
                done_r <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // interrupt request
    // ----------------------------------------
    always_comb begin
        irq_o = 1'b0;
        if (!irq_mask_i) begin
            irq_o = (ctrl2_r[`SLTX_C2_HOLD_IE] & hold_empty_r)
                | (ctrl2_r[`SLTX_C2_DONE_IE] & done_r)
                | (ctrl2_r[`SLTX_C2_RX_IE] & (rx_i.overrun | rx_i.rx_full))
                | (ctrl2_r[`SLTX_C2_IDLE_IE] & rx_i.idle_line);
        end
    end

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    a_ack_one_cycle: assert property (@(posedge clk_i) disable iff (rst_i)
        ack_r |=> !ack_r) else $error("ack held too long");
    a_start_bit_low: assert property (@(posedge clk_i) disable iff (rst_i)
        (state_r == SLTX_DATA_FR && pos == 4'h0) |=> !tx_o) else $error("start bit not low");
    a_break_low: assert property (@(posedge clk_i) disable iff (rst_i)
        (state_r == SLTX_BREAK_FR && cnt_r <= break_len) |=> !tx_o) else $error("break not low");
    a_idle_high: assert property (@(posedge clk_i) disable iff (rst_i)
        (state_r == SLTX_IDLE_FR || state_r == SLTX_READY) |=> tx_o) else $error("idle not high");
    a_done_sets: assert property (@(posedge clk_i) disable iff (rst_i)
        (frame_end && state_r == SLTX_DATA_FR) |=> done_r) else $error("frame done missing");
    a_direct_empty: assert property (@(posedge clk_i) disable iff (rst_i)
        load_direct |=> hold_empty_r && state_r == SLTX_DATA_FR) else $error("direct load wrong");
    a_clear_seq: assert property (@(posedge clk_i) disable iff (rst_i)
        (wr_data && !status_seen_r && !hold_empty_r) |=> !hold_empty_r) else $error("bad clear");
    a_irq_masked: assert property (@(posedge clk_i) disable iff (rst_i)
        irq_mask_i |-> !irq_o) else $error("irq while masked");
    a_mute_lock: assert property (@(posedge clk_i) disable iff (rst_i)
        (wr_ctrl2 && mute_lock && !rx_i.wake_seen) |=> $stable(mute_o)) else $error("mute changed");
    a_enable_delay: assert property (@(posedge clk_i) disable iff (rst_i)
        (state_r == SLTX_OFF && te) |=> state_r == SLTX_WAIT) else $error("no enable delay");
    c_data_frame: cover property (@(posedge clk_i) frame_end && state_r == SLTX_DATA_FR);
    c_break_frame: cover property (@(posedge clk_i) state_r == SLTX_BREAK_FR);
    c_hold_load: cover property (@(posedge clk_i) load_hold);
endmodule

// ### logic/sltx_regs.svh
// register offsets, field positions, reset values and timing counts for the serial transmitter
`ifndef SLTX_REGS_SVH
`define SLTX_REGS_SVH
// Notes on behaviour
// - word length 8 or 9 by select; ninth bit comes from ninth_tx_bit field
// - data leaves the serial pin least significant bit first
// - when enabled, shift register drives serial out with matching clock pulses
// - holding-empty clears only on status read followed by data write
// - holding-empty set by hardware; irq when enable bit 7 and mask clear
// - data written while busy waits in holding buffer until character ends
// - data written while idle loads shifter, starts, holding-empty set at once
// - frame-done set after stop bit or break; irq with bit 6 and mask clear
// - frame-done clears by same status-read then data-write sequence
// - send-break bit 0 repeats breaks sized by word length; then one high bit
// - lin master mode makes break 13 low bits; software keeps 8-bit words
// - setting transmit enable sends one idle frame before first data
// - enable toggled off-on mid word: idle after word, holding data dropped
// - one bit time delay after enable before transmission starts
// - break bit set then cleared sends one break word after current word
// - receiver irq enable bit 5 requests irq on overrun or receive full
// - idle irq enable bit 4 requests irq when idle-line flag set
// - receiver enable bit 2 starts start-bit hunting; clear disables receiver
// - mute bit 1 set and cleared by software, cleared by hardware wake-up
// - with address-mark wake-up, mute writes ignored while receive full set
// - start bit low, stop bit high on every character
// - idle frame is 10 high bit times in 8-bit mode, 11 in 9-bit mode

// ----------------------------------------
// register byte addresses
// ----------------------------------------
`define SLTX_STATUS_ADDR 8'h00
`define SLTX_DATA_ADDR 8'h04
`define SLTX_CTRL1_ADDR 8'h08
`define SLTX_CTRL2_ADDR 8'h0C

// ----------------------------------------
// field positions
// ----------------------------------------
`define SLTX_C2_HOLD_IE 7
`define SLTX_C2_DONE_IE 6
`define SLTX_C2_RX_IE 5
`define SLTX_C2_IDLE_IE 4
`define SLTX_C2_TX_EN 3
`define SLTX_C2_RX_EN 2
`define SLTX_C2_MUTE 1
`define SLTX_C2_BREAK 0
`define SLTX_C1_NINTH 6
`define SLTX_C1_WORD9 4
`define SLTX_C1_WAKE 3
`define SLTX_C1_LIN 1
`define SLTX_SR_HOLD 7
`define SLTX_SR_DONE 6
`define SLTX_SR_FULL 5
`define SLTX_SR_IDLE 4
`define SLTX_SR_OVR 3

// ----------------------------------------
// reset values and frame lengths
// ----------------------------------------
`define SLTX_CTRL2_RST 8'h00
`define SLTX_CTRL1_RST 8'h00
`define SLTX_LEN8 4'hA
`define SLTX_LEN9 4'hB
`define SLTX_LIN_BREAK 4'hD
`endif

// ### logic/sltx_pkg.sv
// types for the serial transmitter
package sltx_pkg;
    typedef enum logic [2:0] {
        SLTX_OFF,
        SLTX_WAIT,
        SLTX_IDLE_FR,
        SLTX_READY,
        SLTX_DATA_FR,
        SLTX_BREAK_FR,
        SLTX_MARK
    } sltx_state_e;
    typedef struct packed {
        logic [7:0] adr;
        logic [7:0] dat;
        logic we;
        logic stb;
    } sltx_req_s;
    typedef struct packed {
        logic overrun;
        logic rx_full;
        logic idle_line;
        logic wake_seen;
    } sltx_rx_s;
endpackage

// ### verification/sltx_line_node.sv
// far-side serial node that decodes words and breaks seen on the line
`timescale 1ns/1ps
module sltx_line_node (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic tick_i,
    input wire logic line_i,
    input wire logic word9_i,
    output logic [8:0] word_o,
    output logic [7:0] words_o,
    output logic [7:0] breaks_o,
    output logic [7:0] low_run_o
);
    // ----------------------------------------
    // sampling mid-bit
    // ----------------------------------------
    logic [3:0] ph_r;
    logic busy_r;
    logic [3:0] idx_r;
    logic [8:0] sh_r;
    logic [7:0] lows_r;
    // sample four clocks after the tick, well clear of the one-clock lag on the line
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ph_r <= 4'hF;
            busy_r <= 1'b0;
            idx_r <= 4'h0;
            sh_r <= 9'h000;
            lows_r <= 8'h00;
            word_o <= 9'h000;
            words_o <= 8'h00;
            breaks_o <= 8'h00;
            low_run_o <= 8'h00;
        end else begin
            if (tick_i) begin
                ph_r <= 4'h0;
            end else if (ph_r != 4'hF) begin
                ph_r <= ph_r + 4'h1;
            end
            if (ph_r == 4'h3) begin
                lows_r <= line_i ? 8'h00 : lows_r + 8'h01;
                if (line_i && lows_r != 8'h00) begin
                    low_run_o <= lows_r;
                end
                if (!busy_r) begin
                    // only a falling edge after a high sample counts as a start
                    if (!line_i && lows_r == 8'h00) begin
                        busy_r <= 1'b1;
                        idx_r <= 4'h0;
                    end
                end else if (idx_r < (word9_i ? 4'h9 : 4'h8)) begin
                    sh_r[idx_r] <= line_i;
                    idx_r <= idx_r + 4'h1;
                end else begin
                    busy_r <= 1'b0;
                    if (line_i) begin
                        word_o <= word9_i ? sh_r : {1'b0, sh_r[7:0]};
                        words_o <= words_o + 8'h01;
                    end else begin
                        breaks_o <= breaks_o + 8'h01;
                    end
                end
            end
        end
    end
endmodule

// ### verification/serial_tx_lin_master_ctrl_test.sv
// self-checking bench for the serial transmitter and control register two
`timescale 1ns/1ps
`include "sltx_regs.svh"
module serial_tx_lin_master_ctrl_test;
    import sltx_pkg::*;
    typedef struct packed {logic [7:0] c1; logic [7:0] d; logic [8:0] w;} sltx_row_s;
    // ctrl one: bit 6 ninth bit, bit 4 nine-bit words
    localparam sltx_row_s ROWS [5] = '{'{8'h00, 8'hA5, 9'h0A5}, '{8'h00, 8'h01, 9'h001},
        '{8'h00, 8'h80, 9'h080}, '{8'h50, 8'h3C, 9'h13C}, '{8'h10, 8'hFF, 9'h0FF}};
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0, tick = 1'b0, mask = 1'b1, word9 = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'h0;
    logic [31:0] wdat = 32'h0, rdat, rd;
    logic ack, tx, sclk, act, rxen, mute, irq;
    sltx_rx_s rx = '0;
    logic [8:0] word;
    logic [7:0] words, breaks, low_run;
    logic [3:0] tcnt = 4'h0;
    int miscompares = 0, tests_run = 0, pulses, n, k;
    always #5 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        tcnt <= tcnt + 4'h1;
        tick <= (tcnt[2:0] == 3'h7);
    end
    sltx_core i_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
        .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack), .baud_tick_i(tick), .irq_mask_i(mask),
        .rx_i(rx), .tx_o(tx), .sclk_o(sclk), .tx_active_o(act), .rx_enable_o(rxen), .mute_o(mute),
        .irq_o(irq));
    sltx_line_node i_node (.clk_i(clk_i), .rst_i(rst_i), .tick_i(tick), .line_i(tx), .word9_i(word9),
        .word_o(word), .words_o(words), .breaks_o(breaks), .low_run_o(low_run));
    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask
    // classic single cycle; request held until ack is sampled high
    task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
        int t;
        t = 0;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= 4'h1;
        wdat <= {24'h0, d};
        do begin
            @(posedge clk_i);
            t++;
        end while (ack !== 1'b1 && t < 20);
        if (t >= 20) begin
            miscompares++;
            final_report();
        end
        rd = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask
    // waits for the word or break count to reach a value, counting clock pulses meanwhile
    task automatic wait_cnt(input logic brk, input logic [7:0] target);
        int t;
        t = 0;
        pulses = 0;
        while ((brk ? breaks : words) !== target && t < 4000) begin
            @(posedge clk_i);
            t++;
            if (sclk === 1'b1) pulses++;
        end
        if (t >= 4000) begin
            miscompares++;
            final_report();
        end
    endtask
    initial begin
        repeat (100000) @(posedge clk_i);
        miscompares++;
        final_report();
    end
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(0, `SLTX_CTRL2_ADDR, 8'h00);
        check("ctrl2 reset", 32'h0, rd);
        check("idle line", 1, tx);
        wb(0, 8'h10, 8'h00);
        check("unmapped read", 32'h0, rd);
        rx.rx_full <= 1'b1;
        wb(1, `SLTX_CTRL2_ADDR, 8'h36);
        wb(0, `SLTX_CTRL2_ADDR, 8'h00);
        check("ctrl2 readback", 32'h36, rd);
        check("rx enable", 1, rxen);
        mask <= 1'b0;
        @(posedge clk_i);
        check("rx irq", 1, irq);
        rx <= '{overrun: 1'b0, rx_full: 1'b1, idle_line: 1'b1, wake_seen: 1'b0};
        wb(1, `SLTX_CTRL1_ADDR, 8'h08);
        wb(1, `SLTX_CTRL2_ADDR, 8'h14);
        check("mute locked", 1, mute);
        check("idle irq", 1, irq);
        rx <= '{overrun: 1'b0, rx_full: 1'b0, idle_line: 1'b0, wake_seen: 1'b1};
        @(posedge clk_i);
        rx.wake_seen <= 1'b0;
        @(posedge clk_i);
        check("wake clears mute", 0, mute);
        wb(1, `SLTX_CTRL1_ADDR, 8'h00);
        mask <= 1'b1;
        // enable aligned just after a tick so bit times count cleanly
        while (tick !== 1'b1) @(posedge clk_i);
        wb(1, `SLTX_CTRL2_ADDR, 8'h08);
        n = 0;
        k = 0;
        fork
            while (tx !== 1'b0 && k < 400) begin
                @(posedge clk_i);
                k++;
                if (tick === 1'b1) n++;
            end
            begin
                wb(0, `SLTX_STATUS_ADDR, 8'h00);
                wb(1, `SLTX_DATA_ADDR, 8'h5A);
            end
        join
        check("ticks to first start", 1, (n >= 11 && n <= 12));
        wait_cnt(0, 8'h01);
        check("first word", 9'h05A, word);
        foreach (ROWS[i]) begin
            word9 <= ROWS[i].c1[4];
            wb(1, `SLTX_CTRL1_ADDR, ROWS[i].c1);
            wb(0, `SLTX_STATUS_ADDR, 8'h00);
            wb(1, `SLTX_DATA_ADDR, ROWS[i].d);
            wait_cnt(0, words + 8'h01);
            check("word", ROWS[i].w, word);
            check("clock pulses", ROWS[i].c1[4] ? 9 : 8, pulses);
            // node decodes mid stop bit; frame-done follows at the end of it
            repeat (8) @(posedge clk_i);
            wb(0, `SLTX_STATUS_ADDR, 8'h00);
            check("flags after frame", 2'b11, rd[7:6]);
        end
        word9 <= 1'b0;
        wb(1, `SLTX_CTRL1_ADDR, 8'h00);
        mask <= 1'b0;
        wb(1, `SLTX_CTRL2_ADDR, 8'h48);
        check("done irq", 1, irq);
        mask <= 1'b1;
        @(posedge clk_i);
        @(posedge clk_i);
        check("done irq masked", 0, irq);
        wb(1, `SLTX_CTRL2_ADDR, 8'h88);
        mask <= 1'b0;
        @(posedge clk_i);
        @(posedge clk_i);
        check("empty irq", 1, irq);
        mask <= 1'b1;
        wb(1, `SLTX_CTRL2_ADDR, 8'h08);
        // idle write starts at once, second write waits in the holding buffer
        wb(0, `SLTX_STATUS_ADDR, 8'h00);
        wb(1, `SLTX_DATA_ADDR, 8'hC3);
        check("active during word", 1, act);
        wb(0, `SLTX_STATUS_ADDR, 8'h00);
        check("empty and done after idle write", 2'b10, rd[7:6]);
        wb(1, `SLTX_DATA_ADDR, 8'h69);
        wb(0, `SLTX_STATUS_ADDR, 8'h00);
        check("holding full", 0, rd[7]);
        wait_cnt(0, words + 8'h01);
        check("first of pair", 9'h0C3, word);
        wait_cnt(0, words + 8'h01);
        check("second of pair", 9'h069, word);
        wait_cnt(0, words);
        wb(1, `SLTX_DATA_ADDR, 8'h11);
        wb(0, `SLTX_STATUS_ADDR, 8'h00);
        wb(1, `SLTX_DATA_ADDR, 8'h22);
        wb(1, `SLTX_DATA_ADDR, 8'h33);
        wb(0, `SLTX_STATUS_ADDR, 8'h00);
        check("no set on bare write", 0, rd[7]);
        wb(1, `SLTX_CTRL2_ADDR, 8'h00);
        wb(1, `SLTX_CTRL2_ADDR, 8'h08);
        n = words;
        wait_cnt(0, n[7:0] + 8'h01);
        check("word before toggle", 9'h011, word);
        repeat (300) @(posedge clk_i);
        check("held word dropped", n[7:0] + 8'h01, words);
        for (int lin = 0; lin < 2; lin++) begin
            wb(1, `SLTX_CTRL1_ADDR, lin ? 8'h02 : 8'h00);
            wb(1, `SLTX_CTRL2_ADDR, 8'h09);
            wb(1, `SLTX_CTRL2_ADDR, 8'h08);
            wait_cnt(1, breaks + 8'h01);
            repeat (40) @(posedge clk_i);
            check("break length", lin ? 13 : 10, low_run);
            check("mark after break", 1, tx);
        end
        wb(0, `SLTX_STATUS_ADDR, 8'h00);
        wb(1, `SLTX_DATA_ADDR, 8'h00);
        rst_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        check("line after reset", 1, tx);
        wb(0, `SLTX_STATUS_ADDR, 8'h00);
        check("empty after reset", 1, rd[7]);
        wb(0, `SLTX_CTRL2_ADDR, 8'h00);
        check("ctrl2 after reset", 32'h0, rd);
        final_report();
    end
endmodule
